// file: include/pps_defs.svh
`ifndef PPS_DEFS_SVH
`define PPS_DEFS_SVH

// register addresses on the management port
`define PPS_ADDR_P1_CTRL13 8'h1D
`define PPS_ADDR_P1_STAT0 8'h1E
`define PPS_ADDR_P1_STAT1 8'h1F
`define PPS_ADDR_P2_CTRL13 8'h2D
`define PPS_ADDR_P2_STAT0 8'h2E
`define PPS_ADDR_P2_STAT1 8'h2F
`define PPS_ADDR_P3_STAT0 8'h3E
`define PPS_ADDR_P3_STAT1 8'h3F

// control-13 fields
`define PPS_C13_LOOPBACK_BIT 0
`define PPS_C13_RESET 8'h00

// status-0 fields
`define PPS_S0_XOVER_BIT 7
`define PPS_S0_NEG_DONE_BIT 6
`define PPS_S0_LINK_GOOD_BIT 5
`define PPS_S0_PAUSE_BIT 4
`define PPS_S0_ABIL_HI 3
`define PPS_S0_ABIL_LO 0

// status-1 fields
`define PPS_S1_XSEL_BIT 7
`define PPS_S1_RSVD_BIT 6
`define PPS_S1_POLRV_BIT 5
`define PPS_S1_TXFC_BIT 4
`define PPS_S1_RXFC_BIT 3
`define PPS_S1_SPEED_BIT 2
`define PPS_S1_DUPLEX_BIT 1
`define PPS_S1_FEF_BIT 0
`define PPS_S1_XSEL_RESET 1'b1

`endif

// file: include/pps_pkg.sv
package pps_pkg;

    // live state of one port as reported by its phy and mac
    typedef struct packed {
        logic crossover_active;
        logic negotiation_complete;
        logic link_good;
        logic partner_pause;
        logic [3:0] partner_abilities;
        logic polarity_reversed;
        logic tx_pause_active;
        logic rx_pause_active;
        logic speed_100;
        logic full_duplex;
        logic far_end_fault;
    } pps_port_state_s;

    // one serial line pair seen at core level
    typedef struct packed {
        logic data;
        logic valid;
    } pps_line_s;

endpackage

// file: core/pps_port_status.sv
`timescale 1ns/1ps
`default_nettype none
`include "pps_defs.svh"

module pps_port_status #(
    parameter bit IS_PHY = 1'b1,
    parameter bit IS_FIBRE = 1'b0
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // live state, already synchronised
    input wire pps_pkg::pps_port_state_s state,
    // selector write
    input wire logic xsel_we,
    input wire logic xsel_wdata,
    // register images
    output logic [7:0] stat0,
    output logic [7:0] stat1,
    output logic crossover_scheme_select
);
    import pps_pkg::*;

    logic xsel_reg;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            xsel_reg <= `PPS_S1_XSEL_RESET;
        end else if (xsel_we && IS_PHY) begin
            xsel_reg <= xsel_wdata;
        end
    end

    // images are pure wiring of the synchronised state and the selector register, so reads never latch or clear
    always_comb begin
        stat0 = 8'h00;
        stat1 = 8'h00;
        if (IS_PHY) begin
            stat0[`PPS_S0_XOVER_BIT] = state.crossover_active;
            stat0[`PPS_S0_NEG_DONE_BIT] = state.negotiation_complete;
            stat0[`PPS_S0_LINK_GOOD_BIT] = state.link_good;
            stat0[`PPS_S0_PAUSE_BIT] = state.partner_pause;
            stat0[`PPS_S0_ABIL_HI:`PPS_S0_ABIL_LO] = state.partner_abilities;
            stat1[`PPS_S1_XSEL_BIT] = xsel_reg;
            stat1[`PPS_S1_POLRV_BIT] = state.polarity_reversed;
        end
        stat1[`PPS_S1_RSVD_BIT] = 1'b0;
        stat1[`PPS_S1_TXFC_BIT] = state.tx_pause_active;
        stat1[`PPS_S1_RXFC_BIT] = state.rx_pause_active;
        stat1[`PPS_S1_SPEED_BIT] = state.speed_100;
        stat1[`PPS_S1_DUPLEX_BIT] = state.full_duplex;
        stat1[`PPS_S1_FEF_BIT] = IS_FIBRE & state.far_end_fault;
    end

    assign crossover_scheme_select = IS_PHY ? xsel_reg : 1'b0;

endmodule
`default_nettype wire

// file: core/pps_status_bank.sv
// Function
// - control-13 bit 0 set enables port loopback; clear returns normal operation.
// - port 1 loopback returns port 2 receive pair data on port 2 transmit pair.
// - port 2 loopback returns port 1 receive pair data on port 1 transmit pair.
// - status-0 read-only at 0x1E and 0x2E; 0x3E reserved, no status.
// - status-0 bit 6 shows negotiation complete; resets to zero.
// - status-0 bit 4 shows partner advertised pause ability.
// - status-0 bits 3..0: partner 100 full, 100 half, 10 full, 10 half.
// - status-1 readable for all three ports at 0x1F, 0x2F, 0x3F.
// - status-1 bit 7 writable crossover selector on ports 1 and 2, resets to one; port 3 reads zero.
// - status-1 bit 6 reserved, reads zero, software leaves it alone.
// - status-1 bit 5 shows reversed receive polarity on ports 1 and 2; port 3 reads zero.
// - status-1 bit 4 shows transmit pause active.
// - status-1 bit 3 shows receive pause active.
// - status-1 bit 2 shows speed: one 100 Mbit, zero 10 Mbit.
// - status-1 bit 1 shows duplex: one full, zero half.
// - status-1 bit 0 far-end fault, port 1 only, else zero.
`timescale 1ns/1ps
`default_nettype none
`include "pps_defs.svh"

module pps_status_bank (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // management register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_hit,
    // live port state from the phys and macs, asynchronous to core_clk
    input wire pps_pkg::pps_port_state_s port1_state,
    input wire pps_pkg::pps_port_state_s port2_state,
    input wire pps_pkg::pps_port_state_s port3_state,
    // line pairs, recovered data at the pma
    input wire pps_pkg::pps_line_s port_one_line_receive_pair,
    input wire pps_pkg::pps_line_s port_two_line_receive_pair,
    input wire pps_pkg::pps_line_s port_one_mac_transmit,
    input wire pps_pkg::pps_line_s port_two_mac_transmit,
    output pps_pkg::pps_line_s port_one_line_transmit_pair,
    output pps_pkg::pps_line_s port_two_line_transmit_pair,
    // phy control outputs
    output logic port1_loopback,
    output logic port2_loopback,
    output logic [1:0] crossover_scheme_select
);
    import pps_pkg::*;

    localparam int SW = $bits(pps_port_state_s);

    logic [SW-1:0] p1_meta, p1_sync;
    logic [SW-1:0] p2_meta, p2_sync;
    logic [SW-1:0] p3_meta, p3_sync;
    logic [7:0] p1_c13_reg, p2_c13_reg;
    logic [7:0] p1_s0, p1_s1, p2_s0, p2_s1, p3_s0, p3_s1;
    logic [7:0] rdata_next;
    logic hit_next;
    logic xsel_we1, xsel_we2, xsel_we3;

    // two-stage synchronisers for the phy state
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            p1_meta <= '0;
            p1_sync <= '0;
            p2_meta <= '0;
            p2_sync <= '0;
            p3_meta <= '0;
            p3_sync <= '0;
        end else begin
            p1_meta <= port1_state;
            p1_sync <= p1_meta;
            p2_meta <= port2_state;
            p2_sync <= p2_meta;
            p3_meta <= port3_state;
            p3_sync <= p3_meta;
        end
    end

    // control-13 of ports 1 and 2; only the loopback bit is held here
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            p1_c13_reg <= `PPS_C13_RESET;
            p2_c13_reg <= `PPS_C13_RESET;
        end else if (reg_wr) begin
            if (reg_addr == `PPS_ADDR_P1_CTRL13) begin
                p1_c13_reg[`PPS_C13_LOOPBACK_BIT] <= reg_wdata[`PPS_C13_LOOPBACK_BIT];
            end else if (reg_addr == `PPS_ADDR_P2_CTRL13) begin
                p2_c13_reg[`PPS_C13_LOOPBACK_BIT] <= reg_wdata[`PPS_C13_LOOPBACK_BIT];
            end
        end
    end

    assign port1_loopback = p1_c13_reg[`PPS_C13_LOOPBACK_BIT];
    assign port2_loopback = p2_c13_reg[`PPS_C13_LOOPBACK_BIT];

    // only bit 7 of status-1 of ports 1 and 2 is writable; bit 6, the status bits and port 3 ignore writes
    assign xsel_we1 = reg_wr && (reg_addr == `PPS_ADDR_P1_STAT1);
    assign xsel_we2 = reg_wr && (reg_addr == `PPS_ADDR_P2_STAT1);
    assign xsel_we3 = reg_wr && (reg_addr == `PPS_ADDR_P3_STAT1);

    pps_port_status #(
        .IS_PHY(1'b1),
        .IS_FIBRE(1'b1)
    ) u_port1 (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .state(pps_port_state_s'(p1_sync)),
        .xsel_we(xsel_we1),
        .xsel_wdata(reg_wdata[`PPS_S1_XSEL_BIT]),
        .stat0(p1_s0),
        .stat1(p1_s1),
        .crossover_scheme_select(crossover_scheme_select[0])
    );

    pps_port_status #(
        .IS_PHY(1'b1),
        .IS_FIBRE(1'b0)
    ) u_port2 (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .state(pps_port_state_s'(p2_sync)),
        .xsel_we(xsel_we2),
        .xsel_wdata(reg_wdata[`PPS_S1_XSEL_BIT]),
        .stat0(p2_s0),
        .stat1(p2_s1),
        .crossover_scheme_select(crossover_scheme_select[1])
    );

    // port 3 is the mii port: no phy, no fibre
    pps_port_status #(
        .IS_PHY(1'b0),
        .IS_FIBRE(1'b0)
    ) u_port3 (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .state(pps_port_state_s'(p3_sync)),
        .xsel_we(xsel_we3),
        .xsel_wdata(reg_wdata[`PPS_S1_XSEL_BIT]),
        .stat0(p3_s0),
        .stat1(p3_s1),
        .crossover_scheme_select()
    );

    // read decode; port 3 status-0 decodes as a hit and reads zero
    always_comb begin
        rdata_next = 8'h00;
        hit_next = 1'b1;
        if (reg_addr == `PPS_ADDR_P1_CTRL13) begin
            rdata_next = p1_c13_reg;
        end else if (reg_addr == `PPS_ADDR_P2_CTRL13) begin
            rdata_next = p2_c13_reg;
        end else if (reg_addr == `PPS_ADDR_P1_STAT0) begin
            rdata_next = p1_s0;
        end else if (reg_addr == `PPS_ADDR_P2_STAT0) begin
            rdata_next = p2_s0;
        end else if (reg_addr == `PPS_ADDR_P1_STAT1) begin
            rdata_next = p1_s1;
        end else if (reg_addr == `PPS_ADDR_P2_STAT1) begin
            rdata_next = p2_s1;
        end else if (reg_addr == `PPS_ADDR_P3_STAT1) begin
            rdata_next = p3_s1;
        end else if (reg_addr == `PPS_ADDR_P3_STAT0) begin
            rdata_next = 8'h00;
        end else begin
            hit_next = 1'b0;
        end
    end

    // read data registered; a read has no side effect on any status bit
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
            reg_hit <= 1'b0;
        end else if (reg_rd) begin
            reg_rdata <= rdata_next;
            reg_hit <= hit_next;
        end
    end

    // loopback at the pma: one port's phy turns the other port's receive data around
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            port_one_line_transmit_pair <= '0;
            port_two_line_transmit_pair <= '0;
        end else begin
            if (port1_loopback) begin
                port_two_line_transmit_pair <= port_two_line_receive_pair;
            end else begin
                port_two_line_transmit_pair <= port_two_mac_transmit;
            end
            if (port2_loopback) begin
                port_one_line_transmit_pair <= port_one_line_receive_pair;
            end else begin
                port_one_line_transmit_pair <= port_one_mac_transmit;
            end
        end
    end

endmodule
`default_nettype wire

// file: sim/pps_status_bank_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module pps_status_bank_monitor (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_hit,
    // live port state
    input wire pps_pkg::pps_port_state_s port1_state,
    input wire pps_pkg::pps_port_state_s port2_state,
    input wire pps_pkg::pps_port_state_s port3_state,
    // line pairs and controls
    input wire pps_pkg::pps_line_s port_one_line_receive_pair,
    input wire pps_pkg::pps_line_s port_two_line_receive_pair,
    input wire pps_pkg::pps_line_s port_one_line_transmit_pair,
    input wire pps_pkg::pps_line_s port_two_line_transmit_pair,
    input wire logic port1_loopback,
    input wire logic port2_loopback,
    input wire logic [1:0] crossover_scheme_select
);
    import pps_pkg::*;
    logic [41:0] d1, d2;
    logic [1:0] rc;
    logic st;
    // status is only comparable once the synchronisers have seen a steady input
    assign st = rc == 2'h3 && d1 == {port1_state, port2_state, port3_state} && d2 == d1;
    always_ff @(posedge core_clk) begin
        d1 <= {port1_state, port2_state, port3_state};
        d2 <= d1;
    end
    always_ff @(posedge core_clk) begin
        if (!rst_n) rc <= 2'h0;
        else if (rc != 2'h3) rc <= rc + 2'h1;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    AST_RST_VAL: assert property ($rose(rst_n) |-> crossover_scheme_select == 2'h3
        && reg_rdata == 8'h00 && !port1_loopback && !port2_loopback) else $error("bad reset");
    AST_S0_P1: assert property (reg_rd && st && reg_addr == 8'h1E
        |=> reg_rdata == $past(port1_state[13:6])) else $error("status-0 port 1 wrong");
    AST_RSVD_P3: assert property (reg_rd && reg_addr == 8'h3E
        |=> reg_rdata == 8'h00 && reg_hit) else $error("reserved place not zero");
    AST_S1_P1: assert property (reg_rd && st && reg_addr == 8'h1F |=>
        reg_rdata == {$past(crossover_scheme_select[0]), 1'b0, $past(port1_state[5:0])})
        else $error("status-1 port 1 wrong");
    AST_S1_P2: assert property (reg_rd && st && reg_addr == 8'h2F |=>
        reg_rdata == {$past(crossover_scheme_select[1]), 1'b0, $past(port2_state[5:1]), 1'b0})
        else $error("status-1 port 2 wrong");
    AST_S1_P3: assert property (reg_rd && st && reg_addr == 8'h3F |=>
        reg_rdata == {3'h0, $past(port3_state[4:1]), 1'b0}) else $error("status-1 port 3 wrong");
    AST_LB_WR: assert property (reg_wr && reg_addr == 8'h1D
        |=> port1_loopback == $past(reg_wdata[0])) else $error("loopback bit not taken");
    AST_XSEL_WR: assert property (reg_wr && reg_addr == 8'h1F
        |=> crossover_scheme_select[0] == $past(reg_wdata[7])) else $error("selector not taken");
    AST_LOOP_P2: assert property (port1_loopback
        |=> port_two_line_transmit_pair == $past(port_two_line_receive_pair))
        else $error("port 2 not looped");
    AST_LOOP_P1: assert property (port2_loopback
        |=> port_one_line_transmit_pair == $past(port_one_line_receive_pair))
        else $error("port 1 not looped");
    AST_HOLD: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("read data moved");
endmodule
bind pps_status_bank pps_status_bank_monitor u_mon (.core_clk, .rst_n, .reg_addr, .reg_wr,
    .reg_rd, .reg_wdata, .reg_rdata, .reg_hit, .port1_state, .port2_state, .port3_state,
    .port_one_line_receive_pair, .port_two_line_receive_pair, .port_one_line_transmit_pair,
    .port_two_line_transmit_pair, .port1_loopback, .port2_loopback, .crossover_scheme_select);
`default_nettype wire

// file: sim/pps_phy_model.sv
`timescale 1ns/1ps
`default_nettype none
module pps_phy_model (
    // clock
    input wire logic core_clk,
    // recovered receive data and mac data
    output var pps_pkg::pps_line_s rx1,
    output var pps_pkg::pps_line_s rx2,
    output var pps_pkg::pps_line_s mac1,
    output var pps_pkg::pps_line_s mac2
);
    import pps_pkg::*;
    // new random pattern every cycle so a stale or stuck path soon fails to match
    initial {rx1, rx2, mac1, mac2} = 8'h00;
    always @(posedge core_clk) {rx1, rx2, mac1, mac2} <= 8'($urandom);
endmodule
`default_nettype wire

// file: sim/pps_status_bank_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fails++; \
    $display("ERROR %0t got %h want %h", $time, a, b); end end
module pps_status_bank_tb;
    import pps_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic reg_wr = 1'b0, reg_rd = 1'b0, reg_hit, lb1, lb2, r;
    logic [1:0] xsel;
    pps_port_state_s ps [1:3];
    pps_line_s rx1, rx2, mac1, mac2, tx1, tx2, e1, e2;
    int fails = 0, checks_done = 0;
    int lb_m [1:2] = '{0, 0};
    int xs_m [1:2] = '{1, 1};
    logic [7:0] addrs [10] = '{8'h1D, 8'h2D, 8'h1E, 8'h2E, 8'h3E, 8'h1F, 8'h2F, 8'h3F, 8'h55, 8'h60};
    logic [7:0] wa [7] = '{8'h1D, 8'h2D, 8'h1F, 8'h2F, 8'h3F, 8'h1E, 8'h55};
    pps_status_bank dut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_hit(reg_hit), .port1_state(ps[1]), .port2_state(ps[2]), .port3_state(ps[3]),
        .port_one_line_receive_pair(rx1), .port_two_line_receive_pair(rx2),
        .port_one_mac_transmit(mac1), .port_two_mac_transmit(mac2),
        .port_one_line_transmit_pair(tx1), .port_two_line_transmit_pair(tx2),
        .port1_loopback(lb1), .port2_loopback(lb2), .crossover_scheme_select(xsel));
    pps_phy_model u_phy (.core_clk(core_clk), .rx1(rx1), .rx2(rx2), .mac1(mac1), .mac2(mac2));
    initial forever #25 core_clk = ~core_clk;
    function automatic logic [8:0] model_rd(input logic [7:0] a);
        case (a)
            8'h1D: return {8'h80, lb_m[1][0]};
            8'h2D: return {8'h80, lb_m[2][0]};
            8'h1E: return {1'b1, ps[1][13:6]};
            8'h2E: return {1'b1, ps[2][13:6]};
            8'h3E: return 9'h100;
            8'h1F: return {1'b1, xs_m[1][0], 1'b0, ps[1][5:0]};
            8'h2F: return {1'b1, xs_m[2][0], 1'b0, ps[2][5:1], 1'b0};
            8'h3F: return {4'h8, ps[3][4:1], 1'b0};
            default: return 9'h000;
        endcase
    endfunction
    task automatic rd(input logic [7:0] a);
        logic [8:0] e;
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        e = model_rd(a);
        #1;
        `CHK({reg_hit, reg_rdata}, e)
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        #1;
        if (a == 8'h1D) lb_m[1] = d[0];
        if (a == 8'h2D) lb_m[2] = d[0];
        if (a == 8'h1F) xs_m[1] = d[7];
        if (a == 8'h2F) xs_m[2] = d[7];
        `CHK({xsel, lb1, lb2}, {xs_m[2][0], xs_m[1][0], lb_m[1][0], lb_m[2][0]})
    endtask
    task automatic complete_run();
        $display("checks_done %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // transmit pairs follow last cycle's receive or mac data
    always @(posedge core_clk) begin
        r = rst_n;
        e1 = lb_m[2] ? rx1 : mac1;
        e2 = lb_m[1] ? rx2 : mac2;
        #1;
        if (r) begin
            `CHK(tx1, e1)
            `CHK(tx2, e2)
        end
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        fails++;
        complete_run();
    end
    initial begin
        void'($urandom(4005));
        for (int p = 1; p <= 3; p++) ps[p] = 14'($urandom);
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
        `CHK({xsel, lb1, lb2, reg_rdata}, 12'hC00)
        for (int i = 0; i < 40; i++) begin
            @(posedge core_clk);
            for (int p = 1; p <= 3; p++) ps[p] <= 14'($urandom);
            repeat (3) @(posedge core_clk);
            foreach (addrs[k]) rd(addrs[k]);
            // software keeps the reserved status-1 bit at zero
            wr(wa[$urandom_range(6, 0)], 8'($urandom) & 8'hBF);
            wr(wa[$urandom_range(6, 0)], 8'($urandom) & 8'hBF);
        end
        complete_run();
    end
endmodule
`default_nettype wire
